//--- design/usr_status_regs.sv
/*
 * Status and special-function register slice of one UART channel,
 * reached over a 32-bit Avalon-MM slave with waitrequest.
 * Assumes the receiver, transmitter and FIFOs report their status on
 * core_stat_i synchronous to clk_i, and the modem pins are synchronous.
 */
// Summary of operation
// RULE1: line status bit 0: receive FIFO not empty
// RULE2: line status bit 1: receive overrun occurred
// RULE3: bits 2/3: parity and framing errors
// RULE4: line status bit 4: break detected
// RULE5: line status bit 5: holding register empty
// RULE6: line status bit 6: shift register empty
// RULE7: line status bit 7: FIFO holds errored data
// RULE8: modem bit 0: CTS changed, read clears
// RULE9: modem bit 1: DSR changed, read clears
// RULE10: modem bit 2: RI rising edge, read clears
// RULE11: modem bit 3: DCD changed, read clears
// RULE12: modem bits 4/5: live CTS, DSR levels
// RULE13: modem bits 6/7: live RI, DCD levels
// RULE14: special bit 0 forces transmission
// RULE15: special bit 1: automatic DSR/DTR flow control
// RULE16: special bit 5 selects extended mode
// RULE17: bit 6: offset 15 error count/RX fill
// RULE18: bit 7: offset 16 TX fill/sample clock
// RULE19: divisor low byte, read/write, resets zero
// RULE20: divisor high byte, resets zero
// RULE21: line control bit 7 selects divisor registers
// RULE22: change during status read is kept
// RULE23: reserved bits 2/3 zero, read-only writes ignored
`timescale 1ns/1ps
`include "usr_regs.svh"

module usr_status_regs (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input usr_pkg::usr_core_stat_t core_stat_i,
   input usr_pkg::usr_modem_pins_t modem_pins_i,
   input wire logic dtr_manual_i,
   output usr_pkg::usr_ctrl_t ctrl_o
);
   import usr_pkg::*;

   // ============================================================
   // Declarations
   usr_main_state_t st_r;
   usr_main_state_t st_nxt;
   logic [5:0] reg_idx;
   logic req;
   logic rd_take;
   logic msr_clr;
   logic [7:0] msr_byte;
   logic [7:0] rd_byte;
   logic [7:0] ls_live;
   logic wr_lane0;

   assign reg_idx = avs_address_i[7:2];
   assign req = avs_read_i | avs_write_i;
   assign wr_lane0 = avs_byteenable_i[0];

   // ============================================================
   // Modem status tracker
   assign rd_take = ce_i && (st_r.bus_st == USR_BUS_IDLE) && avs_read_i;
   assign msr_clr = rd_take && (reg_idx == `USR_IDX_MODEM_STATUS);

   usr_msr_track u_msr (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .pins_i(modem_pins_i),
      .clr_i(msr_clr),
      .modem_input_status_o(msr_byte)
   );

   // ============================================================
   // Line status assembly
   always_comb begin
      ls_live = 8'h00;
      ls_live[`USR_LS_DATA_READY] = |core_stat_i.rx_fifo_fill_count; // RULE1
      ls_live[`USR_LS_OVERRUN] = core_stat_i.rx_overrun; // RULE2
      ls_live[`USR_LS_PARITY] = core_stat_i.rx_parity_err; // RULE3
      ls_live[`USR_LS_FRAMING] = core_stat_i.rx_frame_err; // RULE3
      ls_live[`USR_LS_BREAK] = core_stat_i.rx_break; // RULE4
      ls_live[`USR_LS_THR_EMPTY] = core_stat_i.thr_empty; // RULE5
      ls_live[`USR_LS_TSR_EMPTY] = core_stat_i.tsr_empty; // RULE6
      ls_live[`USR_LS_FIFO_ERR] = core_stat_i.rx_fifo_err; // RULE7
   end

   // ============================================================
   // Read multiplexer
   // Divisor bytes are visible only while the latch enable is set;
   // otherwise those offsets read as zero.
   always_comb begin
      rd_byte = `USR_RST_BYTE;
      unique case (reg_idx)
         `USR_IDX_LINE_CTRL: begin
            rd_byte[`USR_LC_DLAB] = st_r.dlab;
         end
         `USR_IDX_LINE_STATUS: begin
            rd_byte = st_r.line_status;
         end
         `USR_IDX_MODEM_STATUS: begin
            rd_byte = msr_byte;
         end
         `USR_IDX_SPECIAL: begin
            rd_byte = st_r.special & `USR_SF_WRITE_MASK; // RULE23
         end
         `USR_IDX_DIV_LOW: begin
            if (st_r.dlab) begin // RULE21
               rd_byte = st_r.div_low; // RULE19
            end
         end
         `USR_IDX_DIV_HIGH: begin
            if (st_r.dlab) begin // RULE21
               rd_byte = st_r.div_high; // RULE20
            end
         end
         `USR_IDX_AUX_RX: begin
            if (st_r.special[`USR_SF_AUX_RX_SEL]) begin // RULE17
               rd_byte = core_stat_i.err_count;
            end else begin
               rd_byte = core_stat_i.rx_fifo_fill_count;
            end
         end
         `USR_IDX_AUX_TX: begin
            if (st_r.special[`USR_SF_AUX_TX_SEL]) begin // RULE18
               rd_byte = core_stat_i.tx_fifo_fill_count;
            end else begin
               rd_byte = core_stat_i.sample_clock_setting;
            end
         end
         default: begin
            rd_byte = `USR_RST_BYTE;
         end
      endcase
   end

   // ============================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.line_status = ls_live;

      // Flow gating: forced transmission overrides DSR gating, and the
      // automatic mode drops DTR once the receive FIFO nears full.
      if (st_r.special[`USR_SF_FORCE_TX]) begin // RULE14
         st_nxt.tx_allow = 1'b1;
      end else if (st_r.special[`USR_SF_AUTO_DSR_DTR]) begin // RULE15
         st_nxt.tx_allow = modem_pins_i.dsr;
      end else begin
         st_nxt.tx_allow = 1'b1;
      end
      if (st_r.special[`USR_SF_AUTO_DSR_DTR]) begin // RULE15
         st_nxt.dtr = core_stat_i.rx_fifo_fill_count < `USR_DTR_FULL_LEVEL;
      end else begin
         st_nxt.dtr = dtr_manual_i;
      end

      unique case (st_r.bus_st)
         USR_BUS_IDLE: begin
            if (req) begin
               st_nxt.bus_st = USR_BUS_ACK;
               if (avs_read_i) begin
                  st_nxt.rdata = rd_byte;
               end
            end
         end
         USR_BUS_ACK: begin
            st_nxt.bus_st = USR_BUS_IDLE;
            // Writes land on the edge that completes the transfer.
            // Status offsets have no write path at all.
            if (avs_write_i && wr_lane0) begin // RULE23
               unique case (reg_idx)
                  `USR_IDX_LINE_CTRL: begin
                     st_nxt.dlab = avs_writedata_i[`USR_LC_DLAB]; // RULE21
                  end
                  `USR_IDX_SPECIAL: begin
                     st_nxt.special = avs_writedata_i[7:0] & `USR_SF_WRITE_MASK;
                  end
                  `USR_IDX_DIV_LOW: begin
                     if (st_r.dlab) begin // RULE21
                        st_nxt.div_low = avs_writedata_i[7:0]; // RULE19
                     end
                  end
                  `USR_IDX_DIV_HIGH: begin
                     if (st_r.dlab) begin // RULE21
                        st_nxt.div_high = avs_writedata_i[7:0]; // RULE20
                     end
                  end
                  default: begin
                     st_nxt.bus_st = USR_BUS_IDLE;
                  end
               endcase
            end
         end
         default: begin
            st_nxt.bus_st = USR_BUS_IDLE;
         end
      endcase
   end

   // ============================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r.bus_st <= USR_BUS_IDLE;
         st_r.rdata <= `USR_RST_BYTE;
         st_r.line_status <= `USR_RST_BYTE;
         st_r.dlab <= 1'b0;
         st_r.special <= `USR_RST_BYTE;
         st_r.div_low <= `USR_RST_BYTE; // RULE19
         st_r.div_high <= `USR_RST_BYTE; // RULE20
         st_r.tx_allow <= 1'b1;
         st_r.dtr <= 1'b0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   // ============================================================
   // Outputs
   // The answer is withheld while the clock enable is low, so a frozen
   // slave never completes a transfer.
   assign avs_waitrequest_o = req && !(ce_i && (st_r.bus_st == USR_BUS_ACK));
   assign avs_readdata_o = {24'h00_0000, st_r.rdata};

   always_comb begin
      ctrl_o.divisor = {st_r.div_high, st_r.div_low}; // RULE20
      ctrl_o.dlab = st_r.dlab;
      ctrl_o.force_tx = st_r.special[`USR_SF_FORCE_TX]; // RULE14
      ctrl_o.auto_dsr_dtr = st_r.special[`USR_SF_AUTO_DSR_DTR]; // RULE15
      ctrl_o.ext_mode = st_r.special[`USR_SF_EXT_MODE]; // RULE16
      ctrl_o.aux_rx_sel = st_r.special[`USR_SF_AUX_RX_SEL];
      ctrl_o.aux_tx_sel = st_r.special[`USR_SF_AUX_TX_SEL];
      ctrl_o.tx_allow = st_r.tx_allow;
      ctrl_o.dtr = st_r.dtr;
   end

endmodule

//--- design/usr_regs.svh
/*
 * Register indices, bit positions, reset values and levels of the UART
 * status and special-function register slice.
 * Assumes a 32-bit Avalon-MM slave; byte address is four times the index.
 */
`ifndef USR_REGS_SVH
`define USR_REGS_SVH

// ============================================================
// Register indices
`define USR_IDX_LINE_CTRL 6'h03
`define USR_IDX_LINE_STATUS 6'h05
`define USR_IDX_MODEM_STATUS 6'h06
`define USR_IDX_SPECIAL 6'h07
`define USR_IDX_DIV_LOW 6'h08
`define USR_IDX_DIV_HIGH 6'h09
`define USR_IDX_AUX_RX 6'h0F
`define USR_IDX_AUX_TX 6'h10

// ============================================================
// Line status bit positions
`define USR_LS_DATA_READY 0
`define USR_LS_OVERRUN 1
`define USR_LS_PARITY 2
`define USR_LS_FRAMING 3
`define USR_LS_BREAK 4
`define USR_LS_THR_EMPTY 5
`define USR_LS_TSR_EMPTY 6
`define USR_LS_FIFO_ERR 7

// ============================================================
// Modem status bit positions
`define USR_MS_DELTA_CTS 0
`define USR_MS_DELTA_DSR 1
`define USR_MS_RISE_RI 2
`define USR_MS_DELTA_DCD 3
`define USR_MS_CTS 4
`define USR_MS_DSR 5
`define USR_MS_RI 6
`define USR_MS_DCD 7

// ============================================================
// Special function bit positions
`define USR_SF_FORCE_TX 0
`define USR_SF_AUTO_DSR_DTR 1
`define USR_SF_RSVD_RO_LO 2
`define USR_SF_RSVD_RO_HI 3
`define USR_SF_RSVD_RW 4
`define USR_SF_EXT_MODE 5
`define USR_SF_AUX_RX_SEL 6
`define USR_SF_AUX_TX_SEL 7
`define USR_SF_WRITE_MASK 8'hF3

// ============================================================
// Line control bit position
`define USR_LC_DLAB 7

// ============================================================
// Reset values and levels
`define USR_RST_BYTE 8'h00
`define USR_RST_WORD 32'h0000_0000
`define USR_DTR_FULL_LEVEL 8'h70

`endif

//--- design/usr_pkg.sv
/*
 * Types shared by the UART status register slice.
 * Assumes the header usr_regs.svh holds every number.
 */
package usr_pkg;

   // ============================================================
   // Modem input pins, bit 0 is CTS.
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } usr_modem_pins_t;

   // ============================================================
   // Status reported by the receiver, transmitter and FIFOs.
   typedef struct packed {
      logic [7:0] rx_fifo_fill_count;
      logic [7:0] tx_fifo_fill_count;
      logic [7:0] err_count;
      logic [7:0] sample_clock_setting;
      logic rx_overrun;
      logic rx_parity_err;
      logic rx_frame_err;
      logic rx_break;
      logic thr_empty;
      logic tsr_empty;
      logic rx_fifo_err;
   } usr_core_stat_t;

   // ============================================================
   // Control handed to the rest of the channel.
   typedef struct packed {
      logic [15:0] divisor;
      logic dlab;
      logic force_tx;
      logic auto_dsr_dtr;
      logic ext_mode;
      logic aux_rx_sel;
      logic aux_tx_sel;
      logic tx_allow;
      logic dtr;
   } usr_ctrl_t;

   typedef enum logic [1:0] {
      USR_BUS_IDLE = 2'h0,
      USR_BUS_ACK = 2'h1
   } usr_bus_st_t;

   typedef struct packed {
      logic primed;
      logic [3:0] level;
      logic [3:0] delta;
   } usr_msr_state_t;

   typedef struct packed {
      usr_bus_st_t bus_st;
      logic [7:0] rdata;
      logic [7:0] line_status;
      logic dlab;
      logic [7:0] special;
      logic [7:0] div_low;
      logic [7:0] div_high;
      logic tx_allow;
      logic dtr;
   } usr_main_state_t;

endpackage

//--- design/usr_msr_track.sv
/*
 * Modem status tracker: live pin levels and sticky change flags.
 * Assumes the modem pins are synchronous to clk_i.
 */
`timescale 1ns/1ps
`include "usr_regs.svh"

module usr_msr_track (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input usr_pkg::usr_modem_pins_t pins_i,
   input wire logic clr_i,
   output logic [7:0] modem_input_status_o
);
   import usr_pkg::*;

   usr_msr_state_t st_r;
   usr_msr_state_t st_nxt;
   logic [3:0] pin_v;
   logic [3:0] event_v;

   assign pin_v = pins_i;

   // ============================================================
   // Change detection
   always_comb begin
      event_v = 4'h0;
      if (st_r.primed) begin
         event_v[`USR_MS_DELTA_CTS] = pin_v[0] ^ st_r.level[0]; // RULE8
         event_v[`USR_MS_DELTA_DSR] = pin_v[1] ^ st_r.level[1]; // RULE9
         event_v[`USR_MS_RISE_RI] = pin_v[2] & ~st_r.level[2]; // RULE10
         event_v[`USR_MS_DELTA_DCD] = pin_v[3] ^ st_r.level[3]; // RULE11
      end
   end

   // The first cycle after reset only loads the levels, so a pin that is
   // already high does not report a change.
   always_comb begin
      st_nxt = st_r;
      st_nxt.primed = 1'b1;
      st_nxt.level = pin_v;
      for (int i = 0; i < 4; i++) begin
         st_nxt.delta[i] = (st_r.delta[i] & ~clr_i) | event_v[i]; // RULE22
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign modem_input_status_o = {st_r.level, st_r.delta}; // RULE12 RULE13

endmodule

//--- tb/usr_modem_peer.sv
/* Modem peer model driving the CTS, DSR, RI and DCD levels.
   Assumes the bench calls drive() and that the pins are synchronous. */
`timescale 1ns/1ps
module usr_modem_peer (
   input wire logic clk_i,
   output usr_pkg::usr_modem_pins_t pins_o
);
   import usr_pkg::*;
   // ==========================================
   // Pin levels
   initial pins_o = '0;
   // Levels move only just after a rising edge, like a synchronous peer.
   task automatic drive(input usr_modem_pins_t v);
      @(posedge clk_i);
      pins_o <= v;
   endtask
endmodule

//--- tb/usr_status_regs_properties.sv
/* Concurrent checks on the ports of the status register slice.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "usr_regs.svh"
module usr_status_props (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input usr_pkg::usr_core_stat_t core_stat_i,
   input usr_pkg::usr_modem_pins_t modem_pins_i,
   input usr_pkg::usr_ctrl_t ctrl_o
);
   import usr_pkg::*;
   // ==========================================
   // Helpers
   usr_core_stat_t cs1_r;
   usr_core_stat_t cs2_r;
   always_ff @(posedge clk_i) begin
      cs1_r <= core_stat_i;
      cs2_r <= cs1_r;
   end
   function automatic logic [7:0] ls_f(input usr_core_stat_t c);
      return {c.rx_fifo_err, c.tsr_empty, c.thr_empty, c.rx_break, c.rx_frame_err,
              c.rx_parity_err, c.rx_overrun, |c.rx_fifo_fill_count};
   endfunction
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_rd(int idx);
      avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] == idx;
   endsequence
   sequence s_auto;
      ctrl_o.auto_dsr_dtr && !ctrl_o.force_tx;
   endsequence
   // ==========================================
   // Assertions
   chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
      ##1 ce_i |-> !avs_waitrequest_o) else $error("waitrequest held too long");
   chk_upper_zero: assert property (avs_read_i && !avs_waitrequest_o
      |-> avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
   chk_line_mirror: assert property (s_rd(5)
      |-> avs_readdata_o[7:0] == ls_f(cs2_r)) else $error("line status mismatch");
   chk_modem_live: assert property (s_rd(6)
      |-> avs_readdata_o[7:4] == $past(modem_pins_i, 2)) else $error("modem level mismatch");
   chk_force_tx: assert property (ctrl_o.force_tx |=> ctrl_o.tx_allow)
      else $error("forced transmit blocked");
   chk_dsr_flow: assert property (s_auto ##1 (ctrl_o.auto_dsr_dtr && !ctrl_o.force_tx
      && $stable(modem_pins_i.dsr)) |=> ctrl_o.tx_allow == $past(modem_pins_i.dsr))
      else $error("tx_allow does not follow dsr");
   chk_dtr_level: assert property (ctrl_o.auto_dsr_dtr ##1 (ctrl_o.auto_dsr_dtr
      && $stable(core_stat_i.rx_fifo_fill_count)) |=> ctrl_o.dtr ==
      ($past(core_stat_i.rx_fifo_fill_count) < `USR_DTR_FULL_LEVEL)) else $error("dtr level");
   chk_div_gate: assert property (s_rd(8) ##0 !ctrl_o.dlab
      |-> avs_readdata_o[7:0] == 8'h00) else $error("divisor visible without dlab");
   chk_div_value: assert property (s_rd(8) ##0 ctrl_o.dlab
      |-> avs_readdata_o[7:0] == ctrl_o.divisor[7:0]) else $error("divisor low mismatch");
endmodule
bind usr_status_regs usr_status_props chk_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .core_stat_i(core_stat_i), .modem_pins_i(modem_pins_i), .ctrl_o(ctrl_o));

//--- tb/usr_status_regs_tb.sv
/* Self-checking bench for the status register slice.
   Assumes the slave answers over Avalon-MM and the modem peer model. */
`timescale 1ns/1ps
`include "usr_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module usr_status_regs_tb;
   import usr_pkg::*;
   logic clk_i, srst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, dtr_manual_i;
   logic [7:0] avs_address_i;
   logic [3:0] avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   usr_core_stat_t core_stat_i;
   usr_modem_pins_t modem_pins_i;
   usr_ctrl_t ctrl_o;
   int errors = 0;
   int checks = 0;
   usr_status_regs dut_u (.clk_i, .srst_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .core_stat_i,
      .modem_pins_i, .dtr_manual_i, .ctrl_o);
   usr_modem_peer peer_u (.clk_i, .pins_o(modem_pins_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ==========================================
   // Shared tasks
   task automatic end_sim;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= {idx, 2'h0};
      avs_read_i <= !we;
      avs_write_i <= we;
      avs_writedata_i <= {24'h0, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20) begin
         errors++;
         end_sim();
      end
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, idx, 8'h00, r);
      `CHK(r, {24'h0, e})
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      rd_chk(6'h07, 8'h00);
      `CHK(ctrl_o.tx_allow, 1'b1)
      wr(6'h03, 8'h80);
      rd_chk(6'h08, 8'h00);
      rd_chk(6'h09, 8'h00);
      wr(6'h03, 8'h00);
   endtask
   task automatic t_line;
      usr_core_stat_t c;
      for (int i = 0; i < 8; i++) begin
         c = '0;
         case (i)
            0: c.rx_fifo_fill_count = 8'h01;
            1: c.rx_overrun = 1'b1;
            2: c.rx_parity_err = 1'b1;
            3: c.rx_frame_err = 1'b1;
            4: c.rx_break = 1'b1;
            5: c.thr_empty = 1'b1;
            6: c.tsr_empty = 1'b1;
            default: c.rx_fifo_err = 1'b1;
         endcase
         core_stat_i <= c;
         wr(6'h05, 8'hFF);
         rd_chk(6'h05, 8'h01 << i);
      end
      core_stat_i <= '0;
   endtask
   task automatic t_modem;
      usr_modem_pins_t p;
      p = '0;
      for (int j = 0; j < 4; j++) begin
         p[j] = 1'b1;
         peer_u.drive(p);
         repeat (3) @(posedge clk_i);
         rd_chk(6'h06, {p, 4'(4'h1 << j)});
         rd_chk(6'h06, {p, 4'h0});
         p[j] = 1'b0;
         peer_u.drive(p);
         repeat (3) @(posedge clk_i);
         rd_chk(6'h06, {p, (j == 2) ? 4'h0 : 4'(4'h1 << j)});
         rd_chk(6'h06, {p, 4'h0});
      end
   endtask
   task automatic t_special;
      core_stat_i.err_count <= 8'h5A;
      core_stat_i.tx_fifo_fill_count <= 8'h3C;
      core_stat_i.rx_fifo_fill_count <= 8'h21;
      core_stat_i.sample_clock_setting <= 8'h0D;
      wr(6'h07, 8'hFF);
      rd_chk(6'h07, `USR_SF_WRITE_MASK);
      `CHK({ctrl_o.force_tx, ctrl_o.auto_dsr_dtr, ctrl_o.ext_mode}, 3'h7)
      rd_chk(6'h0F, 8'h5A);
      rd_chk(6'h10, 8'h3C);
      wr(6'h07, 8'h00);
      @(posedge clk_i);
      `CHK({ctrl_o.ext_mode, ctrl_o.aux_rx_sel, ctrl_o.aux_tx_sel}, 3'h0)
      rd_chk(6'h0F, 8'h21);
      rd_chk(6'h10, 8'h0D);
   endtask
   task automatic t_flow;
      usr_modem_pins_t p;
      p = '0;
      wr(6'h07, 8'h02);
      peer_u.drive(p);
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.tx_allow, 1'b0)
      p.dsr = 1'b1;
      peer_u.drive(p);
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.tx_allow, 1'b1)
      p.dsr = 1'b0;
      peer_u.drive(p);
      wr(6'h07, 8'h03);
      repeat (2) @(posedge clk_i);
      `CHK(ctrl_o.tx_allow, 1'b1)
      core_stat_i.rx_fifo_fill_count <= `USR_DTR_FULL_LEVEL;
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.dtr, 1'b0)
      core_stat_i.rx_fifo_fill_count <= `USR_DTR_FULL_LEVEL - 8'h01;
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.dtr, 1'b1)
      wr(6'h07, 8'h00);
      dtr_manual_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.dtr, 1'b0)
      // With the clock enable low the registered DTR level must not move.
      ce_i <= 1'b0;
      dtr_manual_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.dtr, 1'b0)
      ce_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(ctrl_o.dtr, 1'b1)
   endtask
   task automatic t_div;
      wr(6'h08, 8'hA5);
      rd_chk(6'h08, 8'h00);
      wr(6'h03, 8'h80);
      rd_chk(6'h08, 8'h00);
      wr(6'h08, 8'hA5);
      wr(6'h09, 8'h3C);
      rd_chk(6'h08, 8'hA5);
      rd_chk(6'h09, 8'h3C);
      // A write without byte lane 0 must leave the register alone.
      avs_byteenable_i <= 4'hE;
      wr(6'h08, 8'h5A);
      avs_byteenable_i <= 4'hF;
      rd_chk(6'h08, 8'hA5);
      `CHK(ctrl_o.divisor, 16'h3CA5)
      `CHK(ctrl_o.dlab, 1'b1)
      wr(6'h03, 8'h00);
      rd_chk(6'h09, 8'h00);
      rd_chk(6'h20, 8'h00);
      // A reset in mid-run must return both divisor bytes to zero.
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      `CHK(ctrl_o.divisor, 16'h0000)
   endtask
   task automatic t_race;
      usr_modem_pins_t p;
      logic [31:0] r;
      p = '0;
      bus(1'b0, 6'h06, 8'h00, r);
      p.dcd = 1'b1;
      // The pin moves on the edge that raises the read, so the change is
      // seen on the same edge that takes the read and clears the flags.
      fork
         peer_u.drive(p);
         bus(1'b0, 6'h06, 8'h00, r);
      join
      `CHK(r, 32'h0000_0000)
      rd_chk(6'h06, 8'h88);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      srst_i = 1'b1;
      ce_i = 1'b1;
      avs_address_i = 8'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_byteenable_i = 4'hF;
      avs_writedata_i = 32'h0;
      core_stat_i = '0;
      dtr_manual_i = 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      t_reset();
      t_line();
      t_modem();
      t_special();
      t_flow();
      t_div();
      t_race();
      end_sim();
   end
endmodule
